/* src/hpet_defines.svh */
`ifndef HPET_DEFINES_SVH
`define HPET_DEFINES_SVH

`define HPET_CEIL(n, d)   (((n) + (d) - 1) / (d))
`define HPET_FLOOR1(n, d) ((((n) / (d)) < 1) ? 1 : ((n) / (d)))

`define HPET_CLK_NS            100
`define HPET_CLK_FS            (`HPET_CLK_NS * 1000000)
`define HPET_HS_DW             8
`define HPET_NFILT             6
`define HPET_F_CONN            0
`define HPET_F_DISC            1
`define HPET_F_DN_K            2
`define HPET_F_UP_K            3
`define HPET_F_UP_SE0          4
`define HPET_F_CHIRP           5

`define HPET_T_FILT_NS         2500
`define HPET_FILT_CYC          `HPET_CEIL(`HPET_T_FILT_NS, `HPET_CLK_NS)
`define HPET_T_DISC_NS         2000
`define HPET_DISC_CYC          `HPET_CEIL(`HPET_T_DISC_NS, `HPET_CLK_NS)
`define HPET_T_DISC_MAX_NS     2500
`define HPET_DISC_MAX_CYC      `HPET_FLOOR1(`HPET_T_DISC_MAX_NS, `HPET_CLK_NS)
`define HPET_T_RESUME_DN_MS    20
`define HPET_RESUME_DN_CYC     `HPET_CEIL(`HPET_T_RESUME_DN_MS * 1000000, `HPET_CLK_NS)
`define HPET_T_PORT_RST_MS     10
`define HPET_RST_CYC           `HPET_CEIL(`HPET_T_PORT_RST_MS * 1000000, `HPET_CLK_NS)
`define HPET_T_ROOT_RST_MS     50
`define HPET_ROOT_CYC          `HPET_CEIL(`HPET_T_ROOT_RST_MS * 1000000, `HPET_CLK_NS)
`define HPET_T_SEG_GAP_MS      3
`define HPET_SEG_GAP_CYC       `HPET_FLOOR1(`HPET_T_SEG_GAP_MS * 1000000, `HPET_CLK_NS)
`define HPET_T_CHIRP_US        40
`define HPET_CHIRP_CYC         `HPET_CEIL(`HPET_T_CHIRP_US * 1000, `HPET_CLK_NS)
`define HPET_T_CHIRP_END_US    100
`define HPET_CHIRP_END_CYC     `HPET_CEIL(`HPET_T_CHIRP_END_US * 1000, `HPET_CLK_NS)
`define HPET_T_CHIRP_END_MAX_US 500
`define HPET_CHIRP_END_MAX_CYC `HPET_FLOOR1(`HPET_T_CHIRP_END_MAX_US * 1000, `HPET_CLK_NS)

`define HPET_FS_BIT_FS         83333333
`define HPET_SE0_UP_BITS       23
`define HPET_SE0_UP_CYC        `HPET_FLOOR1(`HPET_SE0_UP_BITS * `HPET_FS_BIT_FS, `HPET_CLK_FS)
`define HPET_EOF_SE0_BITS      2
`define HPET_EOF_SE0_CYC       `HPET_FLOOR1(`HPET_EOF_SE0_BITS * `HPET_FS_BIT_FS, `HPET_CLK_FS)
`define HPET_HS_BIT_FS         2083333
`define HPET_GAP_SAME_BITS     88
`define HPET_GAP_SAME_CYC      `HPET_CEIL(`HPET_GAP_SAME_BITS * `HPET_HS_BIT_FS, `HPET_CLK_FS)
`define HPET_GAP_OPP_BITS      8
`define HPET_GAP_OPP_CYC       `HPET_CEIL(`HPET_GAP_OPP_BITS * `HPET_HS_BIT_FS, `HPET_CLK_FS)
`define HPET_RESP_BITS         192
`define HPET_RESP_CYC          `HPET_FLOOR1(`HPET_RESP_BITS * `HPET_HS_BIT_FS, `HPET_CLK_FS)
`define HPET_LAT_BITS          36
`define HPET_LAT_EXTRA_FS      4000000
`define HPET_LAT_CYC           `HPET_FLOOR1(`HPET_LAT_BITS * `HPET_HS_BIT_FS + `HPET_LAT_EXTRA_FS, `HPET_CLK_FS)

`endif

/* src/hpet_pkg.sv */
package hpet_pkg;
  typedef logic [19:0] hpet_cnt_type;
  typedef logic [15:0] hpet_run_type;
  typedef enum logic [1:0] {RS_IDLE, RS_PULSE, RS_GAP} hpet_rst_state_type;
  typedef enum logic [2:0] {CH_WAIT, CH_DEVK, CH_K, CH_J, CH_DONE} hpet_chirp_state_type;
endpackage

/* src/hpet_filt_if.sv */
`timescale 1ns/1ns
interface hpet_filt_if;
  logic level;
  logic seen;
  modport user (output level, input seen);
  modport filt (input level, output seen);
endinterface

/* src/hpet_filter.sv */
`timescale 1ns/1ns
module hpet_filter
  import hpet_pkg::*;
#(
  parameter int unsigned THR = 25
) (
  input wire logic clk,
  input wire logic rst_sync_n,
  hpet_filt_if.filt fp
);
  localparam int unsigned CW = $clog2(THR + 1);
  localparam logic [CW-1:0] THR_C = CW'(THR);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          seen_q;
  logic          seen_d;

  // Count consecutive cycles of the level, saturating at the threshold
  always_comb begin
    cnt_d = '0;
    if (fp.level) begin
      cnt_d = (cnt_q == THR_C) ? cnt_q : cnt_q + 1'b1;
    end
    seen_d = (cnt_d == THR_C);
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cnt_q  <= '0;
      seen_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      seen_q <= seen_d;
    end
  end

  assign fp.seen = seen_q;
endmodule // hpet_filter

/* src/hpet_top.sv */
`timescale 1ns/1ns
`include "hpet_defines.svh"
module hpet_top
  import hpet_pkg::*;
#(
  parameter int unsigned DW            = `HPET_HS_DW,
  parameter int unsigned RESUME_DN_CYC = `HPET_RESUME_DN_CYC,
  parameter int unsigned RST_CYC       = `HPET_RST_CYC,
  parameter int unsigned ROOT_CYC      = `HPET_ROOT_CYC,
  parameter int unsigned SEG_GAP_CYC   = `HPET_SEG_GAP_CYC,
  parameter int unsigned CHIRP_END_MAX = `HPET_CHIRP_END_MAX_CYC
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          root_hub,
  input  wire logic          dn_attach,
  input  wire logic          dn_k,
  input  wire logic          dn_chirp_k,
  input  wire logic          up_k,
  input  wire logic          up_se0,
  input  wire logic          port_reset_req,
  input  wire logic          resume_req,
  input  wire logic          fs_se0_dn,
  input  wire logic          eof1,
  input  wire logic          eof_se0_en,
  input  wire logic          hs_in_valid,
  input  wire logic [DW-1:0] hs_in_data,
  input  wire logic          hs_in_last,
  input  wire logic          hs_tx_req,
  output logic               connected_q,
  output logic               disc_evt_q,
  output logic               resume_dn_q,
  output logic               resume_up_q,
  output logic               long_k_q,
  output logic               long_se0_q,
  output logic               reset_dn_q,
  output logic               reset_done_q,
  output logic               chirp_valid_q,
  output logic               chirp_k_q,
  output logic               chirp_j_q,
  output logic               se0_up_q,
  output logic               hs_out_valid_q,
  output logic [DW-1:0]      hs_out_data_q,
  output logic               hs_out_last_q,
  output logic               hs_tx_go_q
);
  localparam hpet_cnt_type RESUME_C  = hpet_cnt_type'(RESUME_DN_CYC);
  localparam hpet_cnt_type RST_C     = hpet_cnt_type'(RST_CYC);
  localparam hpet_cnt_type ROOT_C    = hpet_cnt_type'(ROOT_CYC);
  localparam hpet_cnt_type GAP_C     = hpet_cnt_type'(SEG_GAP_CYC);
  localparam hpet_cnt_type CHIRP_C   = hpet_cnt_type'(`HPET_CHIRP_CYC);
  localparam hpet_cnt_type CHEND_C   = hpet_cnt_type'(`HPET_CHIRP_END_CYC);
  localparam logic [4:0]   SE0_C     = 5'(`HPET_SE0_UP_CYC);
  localparam logic [7:0]   OPP_C     = 8'(`HPET_GAP_OPP_CYC);
  localparam int           FILT_C    = `HPET_FILT_CYC;
  localparam int           FILT_LATE = `HPET_FILT_CYC + 2;
  localparam int           DISC_C    = `HPET_DISC_CYC;
  localparam int           DISC_MAX  = `HPET_DISC_MAX_CYC;
  localparam int           RESP_C    = `HPET_RESP_CYC;
  localparam int           SAME_C    = `HPET_GAP_SAME_CYC;
  localparam int           LAT_C     = `HPET_LAT_CYC;
  localparam int unsigned  FILT_THR [`HPET_NFILT] = '{`HPET_FILT_CYC, `HPET_DISC_CYC,
    `HPET_FILT_CYC, `HPET_FILT_CYC, `HPET_FILT_CYC, `HPET_FILT_CYC};

  function automatic hpet_run_type sat_inc(input hpet_run_type v);
    return (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction

  // Reset release
  logic rst_meta_n_q;
  logic rst_sync_n_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n_q <= 1'b0;
      rst_sync_n_q <= 1'b0;
    end else begin
      rst_meta_n_q <= 1'b1;
      rst_sync_n_q <= rst_meta_n_q;
    end
  end

  // Line condition filters
  logic [`HPET_NFILT-1:0] lvl;
  logic [`HPET_NFILT-1:0] seen;
  assign lvl = {dn_chirp_k, up_se0, up_k, dn_k, ~dn_attach, dn_attach};

  genvar gi;
  generate
    for (gi = 0; gi < `HPET_NFILT; gi++) begin : g_filt
      hpet_filt_if u_if ();
      assign u_if.level = lvl[gi];
      assign seen[gi]   = u_if.seen;
      hpet_filter #(.THR(FILT_THR[gi])) u_filt (
        .clk        (clk),
        .rst_sync_n (rst_sync_n_q),
        .fp         (u_if.filt)
      );
    end
  endgenerate

  // Port, resume and repeater state
  hpet_cnt_type  res_cnt_q, res_cnt_d;
  logic [4:0]    se0_cnt_q, se0_cnt_d;
  logic [7:0]    gap_cnt_q, gap_cnt_d;
  logic          eof_q, eof_d;
  logic          pend_q, pend_d;
  logic          conn_d, disc_d, se0_d, go_d;

  always_comb begin
    conn_d = connected_q;
    if (seen[`HPET_F_CONN]) begin
      conn_d = 1'b1;
    end else if (seen[`HPET_F_DISC]) begin
      conn_d = 1'b0;
    end
    disc_d    = seen[`HPET_F_DISC] && connected_q;
    res_cnt_d = res_cnt_q;
    if (res_cnt_q != '0) begin
      res_cnt_d = res_cnt_q - 1'b1;
    end else if (resume_req) begin
      res_cnt_d = RESUME_C;
    end
    se0_cnt_d = fs_se0_dn ? ((se0_cnt_q == SE0_C) ? se0_cnt_q : se0_cnt_q + 1'b1) : 5'h00;
    eof_d     = eof1 && eof_se0_en && !fs_se0_dn && !se0_up_q;
    se0_d     = (fs_se0_dn && se0_cnt_q < SE0_C && !eof_q) || eof_d;
    gap_cnt_d = hs_in_last ? 8'h00 : ((gap_cnt_q == 8'hFF) ? gap_cnt_q : gap_cnt_q + 8'h01);
    go_d      = pend_q && !hs_in_valid && !hs_in_last && (gap_cnt_q >= OPP_C);
    pend_d    = hs_tx_req || (pend_q && !go_d);
  end

  always_ff @(posedge clk or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      connected_q    <= 1'b0;
      disc_evt_q     <= 1'b0;
      res_cnt_q      <= '0;
      resume_dn_q    <= 1'b0;
      resume_up_q    <= 1'b0;
      long_k_q       <= 1'b0;
      long_se0_q     <= 1'b0;
      chirp_valid_q  <= 1'b0;
      se0_cnt_q      <= 5'h00;
      eof_q          <= 1'b0;
      se0_up_q       <= 1'b0;
      gap_cnt_q      <= 8'hFF;
      pend_q         <= 1'b0;
      hs_tx_go_q     <= 1'b0;
      hs_out_valid_q <= 1'b0;
      hs_out_data_q  <= '0;
      hs_out_last_q  <= 1'b0;
    end else begin
      connected_q    <= conn_d;
      disc_evt_q     <= disc_d;
      res_cnt_q      <= res_cnt_d;
      resume_dn_q    <= (res_cnt_d != '0);
      resume_up_q    <= seen[`HPET_F_DN_K];
      long_k_q       <= seen[`HPET_F_UP_K];
      long_se0_q     <= seen[`HPET_F_UP_SE0];
      chirp_valid_q  <= seen[`HPET_F_CHIRP];
      se0_cnt_q      <= se0_cnt_d;
      eof_q          <= eof_d;
      se0_up_q       <= se0_d;
      gap_cnt_q      <= gap_cnt_d;
      pend_q         <= pend_d;
      hs_tx_go_q     <= go_d;
      hs_out_valid_q <= hs_in_valid;
      hs_out_data_q  <= hs_in_data;
      hs_out_last_q  <= hs_in_last;
    end
  end

  // Downstream reset and chirp sequence
  hpet_rst_state_type   rs_q, rs_d;
  hpet_chirp_state_type ch_q, ch_d;
  hpet_cnt_type         rcnt_q, rcnt_d, tot_q, tot_d, ccnt_q, ccnt_d;
  logic                 root_q, root_d, done_d, room;

  always_comb begin
    rs_d   = rs_q;
    rcnt_d = rcnt_q + 1'b1;
    tot_d  = tot_q + 1'b1;
    root_d = root_q;
    done_d = 1'b0;
    unique case (rs_q)
      RS_IDLE: begin
        rcnt_d = '0;
        tot_d  = '0;
        if (port_reset_req) begin
          rs_d   = RS_PULSE;
          root_d = root_hub;
        end
      end
      RS_PULSE: begin
        if (rcnt_q == RST_C - 1'b1) begin
          rcnt_d = '0;
          if (root_q && tot_q + 1'b1 < ROOT_C) begin
            rs_d = RS_GAP;
          end else begin
            rs_d   = RS_IDLE;
            done_d = 1'b1;
          end
        end
      end
      RS_GAP: begin
        if (rcnt_q == GAP_C - 1'b1) begin
          rcnt_d = '0;
          rs_d   = RS_PULSE;
        end
      end
    endcase
    room   = (rcnt_q + CHIRP_C + 1'b1 < RST_C - CHEND_C);
    ch_d   = ch_q;
    ccnt_d = ccnt_q + 1'b1;
    unique case (ch_q)
      CH_WAIT: begin
        if (seen[`HPET_F_CHIRP]) begin
          ch_d = CH_DEVK;
        end
      end
      CH_DEVK: begin
        ccnt_d = '0;
        if (!seen[`HPET_F_CHIRP]) begin
          ch_d = room ? CH_K : CH_DONE;
        end
      end
      CH_K, CH_J: begin
        if (ccnt_q == CHIRP_C - 1'b1) begin
          ccnt_d = '0;
          ch_d   = !room ? CH_DONE : (ch_q == CH_K) ? CH_J : CH_K;
        end
      end
      CH_DONE: begin
        ccnt_d = '0;
      end
    endcase
    if (rs_d != RS_PULSE) begin
      ch_d   = CH_WAIT;
      ccnt_d = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      rs_q         <= RS_IDLE;
      ch_q         <= CH_WAIT;
      rcnt_q       <= '0;
      tot_q        <= '0;
      ccnt_q       <= '0;
      root_q       <= 1'b0;
      reset_dn_q   <= 1'b0;
      reset_done_q <= 1'b0;
      chirp_k_q    <= 1'b0;
      chirp_j_q    <= 1'b0;
    end else begin
      rs_q         <= rs_d;
      ch_q         <= ch_d;
      rcnt_q       <= rcnt_d;
      tot_q        <= tot_d;
      ccnt_q       <= ccnt_d;
      root_q       <= root_d;
      reset_dn_q   <= (rs_d == RS_PULSE);
      reset_done_q <= done_d;
      chirp_k_q    <= (ch_d == CH_K);
      chirp_j_q    <= (ch_d == CH_J);
    end
  end

  // Checking helpers
  hpet_run_type run_q [`HPET_NFILT];
  hpet_run_type gap_len_q, se0_run_q, ch_len_q, off_len_q, last_gap_q;
  hpet_cnt_type res_len_q, pls_len_q;
  logic [31:0]  tot_len_q;

  for (gi = 0; gi < `HPET_NFILT; gi++) begin : g_run
    always_ff @(posedge clk or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
        run_q[gi] <= 16'h0000;
      end else begin
        run_q[gi] <= lvl[gi] ? sat_inc(run_q[gi]) : 16'h0000;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      res_len_q  <= '0;
      pls_len_q  <= '0;
      gap_len_q  <= 16'h0000;
      se0_run_q  <= 16'h0000;
      ch_len_q   <= 16'h0000;
      off_len_q  <= 16'h0000;
      last_gap_q <= 16'hFFFF;
      tot_len_q  <= 32'h00000000;
    end else begin
      res_len_q  <= resume_dn_q ? res_len_q + 1'b1 : '0;
      pls_len_q  <= reset_dn_q ? pls_len_q + 1'b1 : '0;
      gap_len_q  <= reset_dn_q ? 16'h0000 : sat_inc(gap_len_q);
      se0_run_q  <= se0_up_q ? sat_inc(se0_run_q) : 16'h0000;
      ch_len_q   <= (chirp_k_q != $past(chirp_k_q)) ? 16'h0001 : sat_inc(ch_len_q);
      off_len_q  <= (chirp_k_q || chirp_j_q) ? 16'h0000 : sat_inc(off_len_q);
      last_gap_q <= hs_out_last_q ? 16'h0000 : sat_inc(last_gap_q);
      tot_len_q  <= (reset_dn_q || rs_q == RS_GAP) ? tot_len_q + 32'h00000001 : 32'h00000000;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n_q);

  chk_conn_window: assert property (
    ($rose(connected_q) |-> run_q[0] >= FILT_C) and (run_q[0] == FILT_LATE |-> connected_q))
    else $error("connect flagged outside its window");
  chk_disc_window: assert property (
    $rose(disc_evt_q) |-> run_q[1] >= DISC_C && run_q[1] <= DISC_MAX + 1)
    else $error("disconnect flagged outside its window");
  chk_resume_len: assert property (
    $fell(resume_dn_q) |-> res_len_q == RESUME_DN_CYC)
    else $error("resume drive length wrong");
  chk_resume_rebroad: assert property (
    run_q[2] == FILT_LATE |-> resume_up_q)
    else $error("resume not rebroadcast in time");
  chk_reset_pulse: assert property (
    $fell(reset_dn_q) |-> pls_len_q == RST_CYC)
    else $error("reset pulse length wrong");
  chk_root_total: assert property (
    reset_done_q && root_q |-> tot_len_q >= ROOT_CYC)
    else $error("root reset too short overall");
  chk_seg_gap: assert property (
    $rose(reset_dn_q) && rs_q == RS_PULSE && $past(rs_q) == RS_GAP |-> gap_len_q <= SEG_GAP_CYC)
    else $error("reset segment gap too long");
  chk_long_k: assert property (
    ($rose(long_k_q) |-> run_q[3] >= FILT_C) and (run_q[3] == FILT_LATE |-> long_k_q))
    else $error("long K detect outside window");
  chk_long_se0: assert property (
    ($rose(long_se0_q) |-> run_q[4] >= FILT_C) and (run_q[4] == FILT_LATE |-> long_se0_q))
    else $error("long SE0 detect outside window");
  chk_se0_limit: assert property (
    se0_run_q <= `HPET_SE0_UP_CYC)
    else $error("SE0 repeated upstream too long");
  chk_eof_se0: assert property (
    eof1 && eof_se0_en && !fs_se0_dn && !se0_up_q |=> se0_up_q ##1 (!se0_up_q || fs_se0_dn))
    else $error("frame end SE0 wrong length");
  chk_tx_gap: assert property (
    $rose(hs_tx_go_q) |-> !hs_out_valid_q && last_gap_q >= 1)
    else $error("response gap too short");
  chk_same_gap: assert property (
    $rose(hs_out_valid_q) && last_gap_q < SAME_C |-> gap_cnt_q <= SAME_C)
    else $error("same direction gap shortened");
  chk_resp_time: assert property (
    hs_in_last && hs_tx_req |=> ##[0:RESP_C] hs_tx_go_q)
    else $error("response started too late");
  chk_chirp_filter: assert property (
    $rose(chirp_valid_q) |-> run_q[5] >= FILT_C)
    else $error("chirp accepted too early");
  chk_chirp_start: assert property (
    ch_q == CH_DEVK && !seen[`HPET_F_CHIRP] && room && rs_d == RS_PULSE |=> ##[0:LAT_C] chirp_k_q)
    else $error("hub chirp K started late");
  chk_chirp_hold: assert property (
    ($fell(chirp_k_q) || $fell(chirp_j_q)) |-> ch_len_q == `HPET_CHIRP_CYC)
    else $error("chirp segment length wrong");
  chk_chirp_end: assert property (
    $fell(reset_dn_q) && $past(ch_q) != CH_WAIT |-> off_len_q >= `HPET_CHIRP_END_CYC
      && off_len_q <= CHIRP_END_MAX)
    else $error("chirp sequence ended outside margin");
  chk_hs_latency: assert property (
    hs_in_valid |=> hs_out_valid_q && hs_out_data_q == $past(hs_in_data))
    else $error("repeat latency not fixed");
  chk_chirp_alt: assert property (
    $fell(chirp_k_q) && reset_dn_q && ch_q != CH_DONE |-> chirp_j_q)
    else $error("chirp K not followed by J");

  cov_connect: cover property ($rose(connected_q));
  cov_root_done: cover property (reset_done_q && root_q);
  cov_chirp_j: cover property ($rose(chirp_j_q));
  cov_tx_go: cover property (hs_tx_go_q);
endmodule // hpet_top

/* verif/hpet_dev_model.sv */
`timescale 1ns/1ns
module hpet_dev_model #(
  parameter int unsigned CHIRP_DLY = 10,
  parameter int unsigned CHIRP_LEN = 40
) (
  input  wire logic clk,
  input  wire logic attach,
  input  wire logic reset_dn,
  output logic      dn_attach,
  output logic      dn_chirp_k
);
  int unsigned cnt_q;
  // Time since the start of the current reset pulse
  always_ff @(posedge clk) begin
    if (!reset_dn) begin
      cnt_q <= 0;
    end else if (cnt_q < CHIRP_DLY + CHIRP_LEN + 1) begin
      cnt_q <= cnt_q + 1;
    end
  end
  // Attached line follows the cable state
  assign dn_attach  = attach;
  // Device chirp K, held well beyond the filter time, once per pulse
  assign dn_chirp_k = reset_dn && cnt_q >= CHIRP_DLY && cnt_q < CHIRP_DLY + CHIRP_LEN;
endmodule // hpet_dev_model

/* verif/hub_port_event_timing_tb.sv */
`timescale 1ns/1ns
`define CHK(name, exp, got) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
  $display("wrong value %s expected %0h seen %0h", name, exp, got); end end
module hub_port_event_timing_tb;
  logic       clk, rst_n, root_hub, attach, dn_attach, dn_k, dn_chirp_k, up_k, up_se0;
  logic       port_reset_req, resume_req, fs_se0_dn, eof1, eof_se0_en;
  logic       hs_in_valid, hs_in_last, hs_tx_req;
  logic [7:0] hs_in_data, hs_out_data_q;
  logic       connected_q, disc_evt_q, resume_dn_q, resume_up_q, long_k_q, long_se0_q;
  logic       reset_dn_q, reset_done_q, chirp_valid_q, chirp_k_q, chirp_j_q, se0_up_q;
  logic       hs_out_valid_q, hs_out_last_q, hs_tx_go_q;
  int         bad_count, checks_done;

  always #50 clk = ~clk;

  hpet_dev_model i_dev (.clk(clk), .attach(attach), .reset_dn(reset_dn_q),
    .dn_attach(dn_attach), .dn_chirp_k(dn_chirp_k));

  hpet_top #(.RESUME_DN_CYC(50), .RST_CYC(3000), .ROOT_CYC(12000), .SEG_GAP_CYC(20)) i_dut (
    .clk(clk), .rst_n(rst_n), .root_hub(root_hub), .dn_attach(dn_attach), .dn_k(dn_k),
    .dn_chirp_k(dn_chirp_k), .up_k(up_k), .up_se0(up_se0), .port_reset_req(port_reset_req),
    .resume_req(resume_req), .fs_se0_dn(fs_se0_dn), .eof1(eof1), .eof_se0_en(eof_se0_en),
    .hs_in_valid(hs_in_valid), .hs_in_data(hs_in_data), .hs_in_last(hs_in_last),
    .hs_tx_req(hs_tx_req), .connected_q(connected_q), .disc_evt_q(disc_evt_q),
    .resume_dn_q(resume_dn_q), .resume_up_q(resume_up_q), .long_k_q(long_k_q),
    .long_se0_q(long_se0_q), .reset_dn_q(reset_dn_q), .reset_done_q(reset_done_q),
    .chirp_valid_q(chirp_valid_q), .chirp_k_q(chirp_k_q), .chirp_j_q(chirp_j_q),
    .se0_up_q(se0_up_q), .hs_out_valid_q(hs_out_valid_q), .hs_out_data_q(hs_out_data_q),
    .hs_out_last_q(hs_out_last_q), .hs_tx_go_q(hs_tx_go_q));

  task automatic cyc();
    @(posedge clk);
    #5;
  endtask

  task automatic set_in(input int sel, input logic v);
    case (sel)
      0: attach = v;
      1: attach = !v;
      2: dn_k = v;
      3: up_k = v;
      default: up_se0 = v;
    endcase
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: return connected_q;
      1: return disc_evt_q;
      2: return resume_up_q;
      3: return long_k_q;
      default: return long_se0_q;
    endcase
  endfunction

  // Short run, one-cycle break, then cycles until the flag rises
  task automatic measure(input int sel, output int n);
    set_in(sel, 1'b1);
    repeat (15) cyc();
    set_in(sel, 1'b0);
    cyc();
    set_in(sel, 1'b1);
    n = 0;
    while (pick(sel) !== 1'b1 && n < 300) begin
      cyc();
      n++;
    end
  endtask

  task automatic t_connect();
    int n;
    measure(0, n);
    `CHK("connect delay ok", 1'b1, n >= 25 && n <= 27)
  endtask

  task automatic t_disconnect();
    int n;
    measure(1, n);
    `CHK("disconnect delay ok", 1'b1, n >= 20 && n <= 25)
    attach = 1'b1;
    repeat (30) cyc();
  endtask

  task automatic t_upstream();
    int n;
    measure(3, n);
    `CHK("long k delay ok", 1'b1, n >= 25 && n <= 27)
    up_k = 1'b0;
    measure(4, n);
    `CHK("long se0 delay ok", 1'b1, n >= 25 && n <= 27)
    up_se0 = 1'b0;
    repeat (5) cyc();
  endtask

  task automatic t_resume();
    int n, hi;
    resume_req = 1'b1;
    cyc();
    resume_req = 1'b0;
    hi = 0;
    repeat (100) begin
      hi += resume_dn_q;
      cyc();
    end
    `CHK("resume drive length", 50, hi)
    measure(2, n);
    `CHK("rebroadcast delay ok", 1'b1, n >= 25 && n <= 27)
    dn_k = 1'b0;
    repeat (5) cyc();
  endtask

  task automatic t_reset_chirp();
    int n, hi, dev_end, seg_t, last_end, rend, done_n;
    logic [1:0] st, prev;
    logic cv;
    n = 0; hi = 0; dev_end = 0; seg_t = 0; last_end = 0; rend = 0; done_n = 0;
    prev = 2'b00; cv = 1'b0; root_hub = 1'b0;
    port_reset_req = 1'b1;
    cyc();
    port_reset_req = 1'b0;
    hi = reset_dn_q;
    while (n < 3200) begin
      cyc();
      n++;
      hi += reset_dn_q;
      if (reset_dn_q === 1'b1) rend = n;
      if (reset_done_q === 1'b1) done_n = n;
      if (dn_chirp_k) dev_end = n;
      if (chirp_valid_q === 1'b1) cv = 1'b1;
      st = {chirp_k_q, chirp_j_q};
      if (st !== prev) begin
        if (prev === 2'b00) begin
          `CHK("first chirp kind", 2'b10, st)
          `CHK("chirp start ok", 1'b1, n - dev_end <= 1000)
        end else begin
          `CHK("chirp hold ok", 1'b1, n - seg_t >= 400 && n - seg_t <= 600)
          if (st !== 2'b00) `CHK("chirp alternation", {prev[0], prev[1]}, st)
          if (st === 2'b00) last_end = n;
        end
        seg_t = n;
      end
      prev = st;
    end
    `CHK("device chirp filtered", 1'b1, cv)
    `CHK("port reset length", 3000, hi)
    `CHK("reset done moment", rend + 1, done_n)
    `CHK("chirp end margin ok", 1'b1, last_end > 0 && rend + 1 - last_end >= 1000 &&
         rend + 1 - last_end <= 5000)
  endtask

  task automatic t_root_reset();
    int n, run, gap, first, last;
    n = 0; run = 0; gap = 0; first = 0; last = 0;
    root_hub = 1'b1;
    port_reset_req = 1'b1;
    cyc();
    port_reset_req = 1'b0;
    root_hub = 1'b0;
    while (n < 12500) begin
      n++;
      if (reset_dn_q === 1'b1) begin
        if (first == 0) first = n;
        last = n;
        run++;
        if (gap > 0) `CHK("segment gap ok", 1'b1, gap <= 20)
        gap = 0;
      end else begin
        if (run > 0) `CHK("segment length", 3000, run)
        run = 0;
        if (first != 0) gap++;
      end
      cyc();
    end
    `CHK("root reset span ok", 1'b1, first > 0 && last - first + 1 >= 12000)
  endtask

  task automatic t_se0_up();
    int hi;
    hi = 0;
    fs_se0_dn = 1'b1;
    repeat (40) begin
      cyc();
      hi += se0_up_q;
    end
    fs_se0_dn = 1'b0;
    repeat (3) cyc();
    `CHK("se0 repeat length", 19, hi)
    for (int en = 0; en < 2; en++) begin
      eof_se0_en = en[0];
      eof1 = 1'b1;
      cyc();
      eof1 = 1'b0;
      hi = se0_up_q;
      repeat (5) begin
        cyc();
        hi += se0_up_q;
      end
      `CHK("eof se0 length", en, hi)
    end
  endtask

  task automatic t_hs();
    int g;
    for (int i = 0; i < 4; i++) begin
      hs_in_valid = 1'b1;
      hs_in_data = 8'hA0 + 8'(i);
      hs_in_last = (i == 3);
      hs_tx_req = (i == 3);
      cyc();
      `CHK("repeated word", {1'b1, 8'hA0 + 8'(i), i == 3},
           {hs_out_valid_q, hs_out_data_q, hs_out_last_q})
    end
    hs_in_valid = 1'b0; hs_in_last = 1'b0; hs_tx_req = 1'b0;
    g = 0;
    for (int j = 1; j < 7; j++) begin
      cyc();
      if (hs_tx_go_q === 1'b1 && g == 0) g = j;
    end
    `CHK("response start cycle", 2, g)
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #3000000;
    bad_count++;
    end_of_test();
  end

  initial begin
    clk = 1'b0; rst_n = 1'b0; root_hub = 1'b0; attach = 1'b0; dn_k = 1'b0; up_k = 1'b0;
    up_se0 = 1'b0; port_reset_req = 1'b0; resume_req = 1'b0; fs_se0_dn = 1'b0; eof1 = 1'b0;
    eof_se0_en = 1'b0; hs_in_valid = 1'b0; hs_in_data = 8'h00; hs_in_last = 1'b0;
    hs_tx_req = 1'b0; bad_count = 0; checks_done = 0;
    repeat (5) @(posedge clk);
    #5 rst_n = 1'b1;
    repeat (3) cyc();
    t_connect();
    t_disconnect();
    t_upstream();
    t_resume();
    t_se0_up();
    t_hs();
    t_reset_chirp();
    t_root_reset();
    end_of_test();
  end
endmodule // hub_port_event_timing_tb
